/* mbd_defs.vh */
// Address map, size, key and reset value constants of the memory and bus decode block.
`ifndef MBD_DEFS_VH
`define MBD_DEFS_VH
`define MBD_PERI_BASE      24'h00_4000
`define MBD_PERI_TOP       24'h00_5fff
`define MBD_GUARD_ADDR     24'h00_4000
`define MBD_RAMSZ_ADDR     24'h00_4002
`define MBD_VECL_ADDR      24'h00_4004
`define MBD_VECH_ADDR      24'h00_4006
`define MBD_PSR_ADDR       24'h00_4008
`define MBD_PWG_FIRST      24'h00_4020
`define MBD_PWG_LAST       24'h00_4026
`define MBD_CLG_FIRST      24'h00_4040
`define MBD_CLG_LAST       24'h00_4054
`define MBD_CLG_SKIP       24'h00_404a
`define MBD_CLG_TRIM       24'h00_4054
`define MBD_ITC_FIRST      24'h00_4080
`define MBD_ITC_NINE       24'h00_4092
`define MBD_ITC_LAST       24'h00_4096
`define MBD_FCW_ADDR       24'h00_41b0
`define MBD_RAM_BASE       24'h00_0000
`define MBD_DRAM_BASE      24'h00_2000
`define MBD_DRAM_TOP       24'h00_203f
`define MBD_FLASH_BASE     24'h00_8000
`define MBD_FLASH_TOP      24'h01_7fff
`define MBD_DBG_BYTES      24'h00_0040
`define MBD_RAM_IMPL       24'h00_0800
`define MBD_GUARD_KEY      16'h0096
`define MBD_RAMSZ_RST      16'h0000
`define MBD_VECL_RST       16'h8000
`define MBD_VECH_RST       16'h0000
`define MBD_FCW_RST        16'h0000
`define MBD_UNDEF_DATA     16'h0000
`endif

/* mbd_split.v */
// Splits a wide access into device-width bus cycles.
`default_nettype none
module mbd_split (
  input  wire       clk_in,
  input  wire       srst_in,
  input  wire       start_in,
  input  wire [1:0] acc_size_in,
  input  wire [1:0] dev_size_in,
  output reg  [1:0] beat_out,
  output reg        busy_out,
  output reg        last_out
);
  reg  [1:0] total;
  reg  [1:0] next_beat;
  // Beats minus one: 8-bit device 16->1, 32->3; 16-bit device 32->1.
  always @* begin
    total = 2'd0;
    if (dev_size_in == 2'd0) begin
      total = (acc_size_in == 2'd2) ? 2'd3 : ((acc_size_in == 2'd1) ? 2'd1 : 2'd0); // RULE_13
    end else if (dev_size_in == 2'd1) begin
      total = (acc_size_in == 2'd2) ? 2'd1 : 2'd0; // RULE_13
    end
    next_beat = beat_out + 2'd1;
    // Flags that the beat closed by the coming edge is the last one.
    last_out  = busy_out ? (next_beat == total) : (total == 2'd0); // RULE_13
  end
  always @(posedge clk_in) begin
    if (srst_in) begin
      beat_out <= 2'd0;
      busy_out <= 1'b0;
    end else if (!busy_out && start_in) begin
      beat_out <= 2'd0;
      busy_out <= (total != 2'd0);
    end else if (busy_out) begin
      beat_out <= next_beat;
      busy_out <= (next_beat != total);
    end
  end
endmodule // mbd_split
`default_nettype wire

/* mbd_decode.v */
// Memory and peripheral address decode with system and flash wait registers.
`default_nettype none
`include "mbd_defs.vh"
// Overview of operation
// RULE_01: Two-bit software field selects the flash read wait cycles.
// RULE_02: Software sets flash wait for a faster clock before raising the clock.
// RULE_03: Top 64 bytes of RAM serve the debugger; application avoids them.
// RULE_04: Three-bit field limits visible RAM size to at most the implemented size.
// RULE_05: Accesses beyond the RAM limit act as reserved space, reading undefined.
// RULE_06: Peripheral registers occupy the 8K-byte window from 0x4000.
// RULE_07: System group: RAM size, vector base low/high, status mirror.
// RULE_08: Power generator group has four halfwords from 0x4020 to 0x4026.
// RULE_09: Clock group spans 0x4040 to 0x4054, skips 0x404a, ends in trim.
// RULE_10: Interrupt level setup halfwords start at 0x4080, twelve in all.
// RULE_11: Unused display RAM works as ordinary read/write RAM.
// RULE_12: Every location is reachable by a 16-bit single cycle access; the code splits a 16-bit power group access into two byte cycles.
// RULE_13: Wider accesses split into two or four device-width cycles.
// RULE_14: Flash read cycle register sits at 0x41b0.
// RULE_15: Unassigned peripheral offsets complete, ignore writes, read undefined.
// RULE_16: Flash reads take one plus wait cycles; the CPU stalls meanwhile.
module mbd_decode (
  input  wire        clk_in,
  input  wire        srst_in,
  input  wire        req_in,
  input  wire        wr_in,
  input  wire [23:0] addr_in,
  input  wire [1:0]  acc_size_in,
  input  wire [15:0] wdata_in,
  input  wire        debug_active_in,
  input  wire [7:0]  cpu_psr_in,
  input  wire [15:0] flash_rdata_in,
  input  wire [15:0] ram_rdata_in,
  input  wire [15:0] peri_rdata_in,
  output reg  [15:0] rdata_out,
  output reg         ready_out,
  output reg         stall_out,
  output reg         ram_sel_out,
  output reg         dram_sel_out,
  output reg         flash_sel_out,
  output reg         dbg_area_out,
  output reg         pwg_sel_out,
  output reg         clg_sel_out,
  output reg         clg_trim_sel_out,
  output reg         itc_sel_out,
  output reg  [3:0]  itc_index_out,
  output reg         periph_ext_sel_out,
  output reg  [23:0] vector_base_out,
  output reg  [1:0]  flash_read_wait_select_out,
  output reg  [2:0]  ram_size_limit_out
);
  // ****************************************
  // Registers and helpers
  // ****************************************
  reg  [15:0] system_write_guard;
  reg  [15:0] ram_size_limit;
  reg  [15:0] vector_base_low;
  reg  [15:0] vector_base_high;
  reg  [15:0] flash_read_cycle_reg;
  reg  [1:0]  wait_cnt;
  reg         flash_busy;
  reg  [15:0] next_rdata;
  reg         hit_ram;
  reg         hit_dram;
  reg         hit_flash;
  reg         hit_peri;
  reg         hit_dbg;
  reg         hit_pwg;
  reg         hit_clg;
  reg         hit_itc;
  reg         hit_local;
  reg         hit_fcw;
  reg  [23:0] ram_limit_top;
  wire        unlocked;
  wire        split_busy;
  wire        split_last;
  reg  [1:0]  dev_size;

  // Returns the visible RAM byte count for a size code.
  function [23:0] ram_bytes;
    input [2:0] code;
    begin
      if (code == 3'd0) begin
        ram_bytes = `MBD_RAM_IMPL;
      end else begin
        ram_bytes = `MBD_RAM_IMPL >> code;
      end
    end
  endfunction

  // True when addr lies inside [lo, hi].
  function in_range;
    input [23:0] a;
    input [23:0] lo;
    input [23:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  assign unlocked = (system_write_guard == `MBD_GUARD_KEY);

  // ****************************************
  // Address decode
  // ****************************************
  always @* begin
    ram_limit_top = ram_bytes(ram_size_limit[2:0]); // RULE_04
    hit_ram   = (addr_in < ram_limit_top); // RULE_05
    hit_dbg   = hit_ram && (addr_in >= (ram_limit_top - `MBD_DBG_BYTES)); // RULE_03
    hit_dram  = in_range(addr_in, `MBD_DRAM_BASE, `MBD_DRAM_TOP); // RULE_11
    hit_flash = in_range(addr_in, `MBD_FLASH_BASE, `MBD_FLASH_TOP);
    hit_peri  = in_range(addr_in, `MBD_PERI_BASE, `MBD_PERI_TOP); // RULE_06
    hit_pwg   = in_range(addr_in, `MBD_PWG_FIRST, `MBD_PWG_LAST + 24'h00_0001); // RULE_08
    hit_clg   = in_range(addr_in, `MBD_CLG_FIRST, `MBD_CLG_LAST + 24'h00_0001) &&
                ({addr_in[23:1], 1'b0} != `MBD_CLG_SKIP); // RULE_09
    hit_itc   = in_range(addr_in, `MBD_ITC_FIRST, `MBD_ITC_LAST + 24'h00_0001); // RULE_10
    hit_fcw   = ({addr_in[23:1], 1'b0} == `MBD_FCW_ADDR); // RULE_14
    hit_local = hit_peri && (addr_in[23:4] == `MBD_GUARD_ADDR >> 4) &&
                (addr_in[3:1] <= 3'd4); // RULE_07
    // Peripheral registers are 16 bits wide except the power group, which is byte wide.
    if (hit_pwg) begin
      dev_size = 2'd0;
    end else if (hit_peri || hit_ram || hit_dram || hit_flash) begin
      dev_size = 2'd1; // RULE_12
    end else begin
      dev_size = 2'd2;
    end
    next_rdata = `MBD_UNDEF_DATA; // RULE_15
    if (hit_local) begin
      if ({addr_in[23:1], 1'b0} == `MBD_GUARD_ADDR) begin
        next_rdata = {15'd0, unlocked};
      end else if ({addr_in[23:1], 1'b0} == `MBD_RAMSZ_ADDR) begin
        next_rdata = {13'd0, ram_size_limit[2:0]};
      end else if ({addr_in[23:1], 1'b0} == `MBD_VECL_ADDR) begin
        next_rdata = vector_base_low;
      end else if ({addr_in[23:1], 1'b0} == `MBD_VECH_ADDR) begin
        next_rdata = {8'd0, vector_base_high[7:0]};
      end else begin
        next_rdata = {8'd0, cpu_psr_in}; // RULE_07
      end
    end else if (hit_fcw) begin
      next_rdata = {14'd0, flash_read_cycle_reg[1:0]};
    end else if (hit_pwg || hit_clg || hit_itc) begin
      next_rdata = peri_rdata_in;
    end else if (hit_ram || hit_dram) begin
      next_rdata = ram_rdata_in;
    end else if (hit_flash) begin
      next_rdata = flash_rdata_in;
    end
  end

  mbd_split u_split (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .start_in    (req_in && !flash_busy && !split_busy),
    .acc_size_in (acc_size_in),
    .dev_size_in (dev_size),
    .beat_out    (),
    .busy_out    (split_busy),
    .last_out    (split_last)
  );

  // ****************************************
  // Registers and bus timing
  // ****************************************
  always @(posedge clk_in) begin
    if (srst_in) begin
      system_write_guard   <= 16'h0000;
      ram_size_limit       <= `MBD_RAMSZ_RST;
      vector_base_low      <= `MBD_VECL_RST;
      vector_base_high     <= `MBD_VECH_RST;
      flash_read_cycle_reg <= `MBD_FCW_RST;
      wait_cnt             <= 2'd0;
      flash_busy           <= 1'b0;
      rdata_out            <= 16'h0000;
      ready_out            <= 1'b0;
      stall_out            <= 1'b0;
      ram_sel_out          <= 1'b0;
      dram_sel_out         <= 1'b0;
      flash_sel_out        <= 1'b0;
      dbg_area_out         <= 1'b0;
      pwg_sel_out          <= 1'b0;
      clg_sel_out          <= 1'b0;
      clg_trim_sel_out     <= 1'b0;
      itc_sel_out          <= 1'b0;
      itc_index_out        <= 4'd0;
      periph_ext_sel_out   <= 1'b0;
      vector_base_out      <= 24'h00_8000;
      flash_read_wait_select_out <= 2'd0;
      ram_size_limit_out   <= 3'd0;
    end else begin
      ready_out <= 1'b0;
      if (req_in && wr_in && !flash_busy) begin
        if ({addr_in[23:1], 1'b0} == `MBD_GUARD_ADDR) begin
          system_write_guard <= wdata_in;
        end else if (hit_local && unlocked &&
                     ({addr_in[23:1], 1'b0} == `MBD_RAMSZ_ADDR)) begin
          ram_size_limit <= {13'd0, wdata_in[2:0]}; // RULE_04
        end else if (hit_local && unlocked &&
                     ({addr_in[23:1], 1'b0} == `MBD_VECL_ADDR)) begin
          vector_base_low <= {wdata_in[15:8], 8'h00};
        end else if (hit_local && unlocked &&
                     ({addr_in[23:1], 1'b0} == `MBD_VECH_ADDR)) begin
          vector_base_high <= {8'd0, wdata_in[7:0]};
        end else if (hit_fcw && unlocked) begin
          flash_read_cycle_reg <= {14'd0, wdata_in[1:0]}; // RULE_01
        end
      end
      // Flash read holds the bus for one plus the selected wait cycles.
      if (req_in && !wr_in && hit_flash && !flash_busy && flash_read_cycle_reg[1:0] != 2'd0) begin
        flash_busy <= 1'b1; // RULE_16
        wait_cnt   <= flash_read_cycle_reg[1:0] - 2'd1;
        stall_out  <= 1'b1;
      end else if (flash_busy) begin
        if (wait_cnt == 2'd0) begin
          flash_busy <= 1'b0; // RULE_16
          stall_out  <= 1'b0;
          ready_out  <= 1'b1;
          rdata_out  <= flash_rdata_in;
        end else begin
          wait_cnt <= wait_cnt - 2'd1;
        end
      end else if (req_in) begin
        stall_out <= !split_last; // RULE_13
        ready_out <= split_last; // RULE_12
        rdata_out <= wr_in ? 16'h0000 : next_rdata; // RULE_15
      end else begin
        stall_out <= split_busy && !split_last;
        ready_out <= split_busy && split_last;
      end
      ram_sel_out        <= req_in && hit_ram;
      dram_sel_out       <= req_in && hit_dram; // RULE_11
      flash_sel_out      <= req_in && hit_flash;
      dbg_area_out       <= req_in && hit_dbg && debug_active_in; // RULE_03
      pwg_sel_out        <= req_in && hit_pwg;
      clg_sel_out        <= req_in && hit_clg;
      clg_trim_sel_out   <= req_in && hit_clg && ({addr_in[23:1], 1'b0} == `MBD_CLG_TRIM);
      itc_sel_out        <= req_in && hit_itc;
      // The level group base is 32-byte aligned, so the offset bits give the index.
      itc_index_out      <= addr_in[4:1]; // RULE_10
      periph_ext_sel_out <= req_in && (hit_pwg || hit_clg || hit_itc);
      vector_base_out    <= {vector_base_high[7:0], vector_base_low};
      flash_read_wait_select_out <= flash_read_cycle_reg[1:0];
      ram_size_limit_out <= ram_size_limit[2:0];
    end
  end
endmodule // mbd_decode
`default_nettype wire

/* mbd_targets.sv */
// Flash, RAM and peripheral data sources behind the decoder.
`default_nettype none
module mbd_targets #(
  parameter logic [15:0] FLASH_PAT = 16'ha5c3,
  parameter logic [15:0] RAM_PAT   = 16'h3c5a
) (
  output wire logic [15:0] flash_rdata_out,
  output wire logic [15:0] ram_rdata_out,
  output wire logic [15:0] peri_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign flash_rdata_out = FLASH_PAT;
  assign ram_rdata_out   = RAM_PAT;
  assign peri_rdata_out  = 16'h0f0f;
endmodule // mbd_targets
`default_nettype wire

/* mbd_decode_asserts.sv */
// Assertion checker for the memory and bus decode block.
`default_nettype none
`include "mbd_defs.vh"
module mbd_decode_asserts (
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        req_in,
  input wire logic        wr_in,
  input wire logic [23:0] addr_in,
  input wire logic [1:0]  acc_size_in,
  input wire logic [7:0]  cpu_psr_in,
  input wire logic [15:0] rdata_out,
  input wire logic        ready_out,
  input wire logic        stall_out,
  input wire logic        ram_sel_out,
  input wire logic        clg_sel_out,
  input wire logic        clg_trim_sel_out,
  input wire logic        itc_sel_out,
  input wire logic [3:0]  itc_index_out,
  input wire logic [1:0]  flash_read_wait_select_out,
  input wire logic [2:0]  ram_size_limit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend, fl;
  logic [2:0] cnt;
  logic [1:0] wt;
  wire        take = req_in && !pend;
  wire        rd16 = take && !wr_in && acc_size_in == 2'h1;
  wire        pwg  = addr_in >= `MBD_PWG_FIRST && addr_in <= `MBD_PWG_LAST;
  wire [23:0] aoff = addr_in - `MBD_ITC_FIRST;
  wire [3:0]  aidx = aoff[4:1];
  wire [23:0] lim  = (ram_size_limit_out == 3'h0) ? `MBD_RAM_IMPL
                     : (`MBD_RAM_IMPL >> ram_size_limit_out);
  always @(posedge clk_in) begin
    if (srst_in) begin
      pend <= 1'b0;
      fl <= 1'b0;
    end else begin
      pend <= take || (pend && !ready_out);
      if (take) begin
        fl <= rd16 && addr_in >= `MBD_FLASH_BASE && addr_in <= `MBD_FLASH_TOP;
        cnt <= 3'h1;
        wt <= flash_read_wait_select_out;
      end else if (ready_out) fl <= 1'b0;
      else cnt <= cnt + 3'h1;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence two_beats;
    !ready_out ##1 ready_out;
  endsequence
  a_flash_wait_cycles: assert property (
    fl |-> cnt <= wt + 3'h1 && ready_out == (cnt == wt + 3'h1)) else $error("flash wait");
  a_flash_stall_held: assert property (
    fl && !ready_out |-> stall_out) else $error("flash stall");
  a_ready_ends_stall: assert property (
    ready_out |-> !stall_out) else $error("stall at ready");
  a_ram_split_beats: assert property (
    take && acc_size_in == 2'h2 && addr_in < lim |=> two_beats) else $error("ram split");
  a_pwg_byte_beats: assert property (
    take && pwg && acc_size_in == 2'h1 |=> two_beats) else $error("byte split");
  a_ram_limit_sel: assert property (
    take && addr_in < `MBD_DRAM_BASE |=> ram_sel_out == ($past(addr_in) < $past(lim)))
    else $error("ram limit");
  a_psr_mirror_read: assert property (
    rd16 && addr_in == `MBD_PSR_ADDR |=> rdata_out == {8'h00, $past(cpu_psr_in)})
    else $error("status mirror");
  a_clg_gap_undef: assert property (
    rd16 && addr_in == `MBD_CLG_SKIP |=> ready_out && !clg_sel_out
    && rdata_out == `MBD_UNDEF_DATA) else $error("clock gap");
  a_trim_reg_sel: assert property (
    take && addr_in == `MBD_CLG_TRIM |=> clg_sel_out && clg_trim_sel_out) else $error("trim");
  a_itc_index_map: assert property (
    take && addr_in >= `MBD_ITC_FIRST && addr_in <= `MBD_ITC_LAST
    |=> itc_sel_out && itc_index_out == $past(aidx)) else $error("level index");
endmodule // mbd_decode_asserts
bind mbd_decode mbd_decode_asserts chk (.clk_in, .srst_in, .req_in, .wr_in, .addr_in,
  .acc_size_in, .cpu_psr_in, .rdata_out, .ready_out, .stall_out, .ram_sel_out, .clg_sel_out,
  .clg_trim_sel_out, .itc_sel_out, .itc_index_out, .flash_read_wait_select_out,
  .ram_size_limit_out);
`default_nettype wire

/* mbd_decode_test.sv */
// Self-checking testbench for the memory and bus decode block.
`default_nettype none
`include "mbd_defs.vh"
module mbd_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] FPAT = 16'ha5c3;
  localparam logic [15:0] RPAT = 16'h3c5a;
  logic        clk_in = 0, srst_in = 1, req_in = 0, wr_in = 0, debug_active_in = 0;
  logic [23:0] addr_in = '0;
  logic [1:0]  acc_size_in = '0;
  logic [15:0] wdata_in = '0, rd;
  logic [7:0]  cpu_psr_in = '0;
  logic [8:0]  sel;
  wire  [15:0] flash_rdata_in, ram_rdata_in, peri_rdata_in, rdata_out;
  wire         ready_out, stall_out, ram_sel_out, dram_sel_out, flash_sel_out, dbg_area_out;
  wire         pwg_sel_out, clg_sel_out, clg_trim_sel_out, itc_sel_out, periph_ext_sel_out;
  wire  [3:0]  itc_index_out;
  wire  [23:0] vector_base_out;
  wire  [1:0]  flash_read_wait_select_out;
  wire  [2:0]  ram_size_limit_out;
  int          errors = 0, checks = 0;
  logic [23:0] ta [12] = '{24'h00_4020, 24'h00_4026, 24'h00_4028, 24'h00_4040, 24'h00_404a,
    24'h00_4054, 24'h00_4080, 24'h00_4092, 24'h00_4096, 24'h00_2010, 24'h00_4010, 24'h00_4200};
  logic [8:0]  te [12] = '{9'h011, 9'h011, 9'h000, 9'h009, 9'h000, 9'h00d, 9'h003, 9'h003,
    9'h003, 9'h080, 9'h000, 9'h000};
  mbd_targets #(.FLASH_PAT(FPAT), .RAM_PAT(RPAT)) tgt (.flash_rdata_out(flash_rdata_in),
    .ram_rdata_out(ram_rdata_in), .peri_rdata_out(peri_rdata_in));
  mbd_decode dut (.clk_in, .srst_in, .req_in, .wr_in, .addr_in, .acc_size_in, .wdata_in,
    .debug_active_in, .cpu_psr_in, .flash_rdata_in, .ram_rdata_in, .peri_rdata_in, .rdata_out,
    .ready_out, .stall_out, .ram_sel_out, .dram_sel_out, .flash_sel_out, .dbg_area_out,
    .pwg_sel_out, .clg_sel_out, .clg_trim_sel_out, .itc_sel_out, .itc_index_out,
    .periph_ext_sel_out, .vector_base_out, .flash_read_wait_select_out, .ram_size_limit_out);
  always #2.5 clk_in = ~clk_in;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [23:0] a, input logic [1:0] s,
                     input logic [15:0] d, input int n);
    int c;
    c = 0;
    @(posedge clk_in);
    {req_in, wr_in, addr_in, acc_size_in, wdata_in} <= {1'b1, w, a, s, d};
    do begin
      @(posedge clk_in);
      c++;
      if (c == n) req_in <= 1'b0;
      #1;
    end while (ready_out !== 1'b1 && c < 20);
    rd = rdata_out;
    sel = {ram_sel_out, dram_sel_out, flash_sel_out, dbg_area_out, pwg_sel_out,
           clg_sel_out, clg_trim_sel_out, itc_sel_out, periph_ext_sel_out};
    chk(24'(c), 24'(n), "cycles");
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    chk({vector_base_out, ram_size_limit_out}, {24'h00_8000, 3'h0}, "reset");
    acc(1'b1, `MBD_RAMSZ_ADDR, 2'h1, 16'h0003, 1);
    acc(1'b0, `MBD_RAMSZ_ADDR, 2'h1, '0, 1);
    chk(rd, '0, "unguarded write");
    acc(1'b1, `MBD_GUARD_ADDR, 2'h1, `MBD_GUARD_KEY, 1);
    acc(1'b1, `MBD_RAMSZ_ADDR, 2'h1, 16'h0003, 1);
    acc(1'b0, `MBD_RAMSZ_ADDR, 2'h1, '0, 1);
    chk({ram_size_limit_out, rd}, {3'h3, 16'h0003}, "limit");
    acc(1'b0, 24'h00_00fc, 2'h1, '0, 1);
    chk({sel[8], rd}, {1'b1, RPAT}, "inside limit");
    acc(1'b0, 24'h00_0100, 2'h1, '0, 1);
    chk({sel[8], rd}, {1'b0, `MBD_UNDEF_DATA}, "beyond limit");
    acc(1'b0, 24'h00_0010, 2'h2, '0, 2);
    acc(1'b0, `MBD_PWG_FIRST, 2'h1, '0, 2);
    acc(1'b0, `MBD_PWG_FIRST, 2'h2, '0, 4);
    acc(1'b1, `MBD_VECL_ADDR, 2'h1, 16'h1234, 1);
    acc(1'b1, `MBD_VECH_ADDR, 2'h1, 16'h0056, 1);
    acc(1'b0, `MBD_VECL_ADDR, 2'h1, '0, 1);
    chk({vector_base_out, rd}, {24'h56_1200, 16'h1200}, "vector");
    @(posedge clk_in) cpu_psr_in <= 8'ha5;
    acc(1'b0, `MBD_PSR_ADDR, 2'h1, '0, 1);
    chk(rd, 16'h00a5, "status mirror");
    for (int w = 0; w < 4; w++) begin
      acc(1'b1, `MBD_FCW_ADDR, 2'h1, 16'(w), 1);
      acc(1'b0, `MBD_FCW_ADDR, 2'h1, '0, 1);
      chk({flash_read_wait_select_out, rd}, {2'(w), 16'(w)}, "wait");
      acc(1'b0, `MBD_FLASH_BASE, 2'h1, '0, w + 1);
      chk(rd, FPAT, "flash data");
      chk(sel[6], 1'b1, "flash select");
    end
    acc(1'b1, `MBD_RAMSZ_ADDR, 2'h1, '0, 1);
    @(posedge clk_in) debug_active_in <= 1'b1;
    acc(1'b0, `MBD_RAM_IMPL - `MBD_DBG_BYTES, 2'h1, '0, 1);
    chk(sel[5], 1'b1, "debug area");
    acc(1'b0, `MBD_RAM_IMPL - `MBD_DBG_BYTES - 24'h2, 2'h1, '0, 1);
    chk(sel[5], 1'b0, "below debug area");
    acc(1'b1, 24'h00_4010, 2'h1, 16'hffff, 1);
    for (int i = 0; i < 12; i++) begin
      acc(1'b0, ta[i], (ta[i][15:4] == 12'h402) ? 2'h0 : 2'h1, '0, 1);
      chk(sel, te[i], "decode");
      if (te[i][1]) chk(itc_index_out, 4'((ta[i] - `MBD_ITC_FIRST) >> 1), "level index");
      if (te[i] == '0) chk(rd, `MBD_UNDEF_DATA, "unassigned");
    end
    close_out();
  end
endmodule // mbd_decode_test
`default_nettype wire
